// >>> cmpd_pkg.sv
package cmpd_pkg;

  // ==========================================================
  // register map and field layout
  localparam logic [6:0] ADDR_CLOCK_MODE = 7'h01;
  localparam logic [6:0] ADDR_POWER_DOWN = 7'h02;
  localparam logic [6:0] ADDR_RX_A_POWER = 7'h03;
  localparam logic [6:0] ADDR_RX_B_POWER = 7'h04;

  localparam int CM_MODE_MSB = 7;
  localparam int CM_MODE_LSB = 5;
  localparam int CM_IF2_EN_BIT = 2;
  localparam int CM_INV3_BIT = 1;
  localparam int PD_TXA_MSB = 7;
  localparam int PD_TXA_LSB = 5;
  localparam int PD_TXDIG_BIT = 4;
  localparam int PD_RXDIG_BIT = 3;
  localparam int PD_PLL_BIT = 2;
  localparam int PD_DISC_BIT = 1;
  localparam int RX_PD_BIT = 7;

  localparam logic [7:0] CLOCK_MODE_RESET = 8'h00;
  localparam logic [7:0] POWER_DOWN_RESET = 8'h00;
  localparam logic [7:0] RX_POWER_RESET = 8'h00;

  // ==========================================================
  // encodings
  localparam logic [2:0] CLK_STD = 3'h0;
  localparam logic [2:0] CLK_ALT_FD = 3'h1;
  localparam logic [2:0] CLK_ALT_HALF_DUPLEX_TWENTY_BIT = 3'h3;
  localparam logic [2:0] CLK_ALT_HALF_DUPLEX_TEN_BIT = 3'h5;
  localparam logic [2:0] CLK_CLONE = 3'h7;

  localparam logic [2:0] TXPD_A = 3'h4;
  localparam logic [2:0] TXPD_B = 3'h2;
  localparam logic [2:0] TXPD_BOTH = 3'h6;

  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int TX_WIDTH = 10;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic std_timing;
    logic alt_fd;
    logic alt_half_duplex_twenty_bit;
    logic alt_half_duplex_ten_bit;
    logic clone;
  } timing_sel_type;

  typedef struct packed {
    logic tx_a_out_en;
    logic tx_b_out_en;
    logic tx_support_pd;
    logic tx_bias_on;
    logic tx_dig_clk_en;
    logic rx_dig_pd;
    logic pll_pd;
    logic pll_out_connect;
    logic rx_a_pd;
    logic rx_b_pd;
  } power_ctrl_type;

  function automatic logic mode_valid(input logic [2:0] code);
    mode_valid = (code == CLK_STD) || (code == CLK_ALT_FD) ||
      (code == CLK_ALT_HALF_DUPLEX_TWENTY_BIT) || (code == CLK_ALT_HALF_DUPLEX_TEN_BIT) ||
      (code == CLK_CLONE);
  endfunction : mode_valid

  function automatic timing_sel_type decode_mode(input logic [2:0] code);
    decode_mode.std_timing = (code == CLK_STD);
    decode_mode.alt_fd = (code == CLK_ALT_FD);
    decode_mode.alt_half_duplex_twenty_bit = (code == CLK_ALT_HALF_DUPLEX_TWENTY_BIT);
    decode_mode.alt_half_duplex_ten_bit = (code == CLK_ALT_HALF_DUPLEX_TEN_BIT);
    decode_mode.clone = (code == CLK_CLONE);
  endfunction : decode_mode

endpackage : cmpd_pkg

// >>> sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= INIT;
      q <= INIT;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sync2
`default_nettype wire

// >>> iface_clock_out.sv
`timescale 1ns/1ps
`default_nettype none
module iface_clock_out (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic if2_en,
  input wire logic fd_active,
  input wire logic inv3,
  output logic pin2_o,
  output logic pin2_oe_n,
  output logic pin3_o,
  output logic pin3_oe_n
);
  logic div_reg;
  logic div_next;

  // ==========================================================
  // half-rate interface clock
  assign div_next = ~div_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg <= 1'b0;
      pin2_o <= 1'b0;
      pin2_oe_n <= 1'b1;
      pin3_o <= 1'b0;
      pin3_oe_n <= 1'b1;
    end else if (ce) begin
      div_reg <= div_next;
      // RULE_06 pin two drives
      pin2_oe_n <= ~if2_en;
      // RULE_07 full-duplex inversion
      pin2_o <= if2_en & (div_next ^ fd_active);
      // RULE_08 pin three inversion
      pin3_o <= div_next ^ inv3;
      pin3_oe_n <= 1'b0;
    end
  end

  AST_PIN3_INV: assert property (@(posedge clk) disable iff (reset) // RULE_08
    ce |=> (pin3_o == (div_reg ^ $past(inv3))))
    else $error("third pin clock polarity wrong");

  AST_PIN2_FD_INV: assert property (@(posedge clk) disable iff (reset) // RULE_07
    (ce && if2_en) |=> (pin2_o == (div_reg ^ $past(fd_active))))
    else $error("second pin clock polarity wrong");

  AST_PIN2_QUIET: assert property (@(posedge clk) disable iff (reset) // RULE_06
    (ce && !if2_en) |=> (pin2_oe_n && !pin2_o))
    else $error("second pin driven while clock disabled");
endmodule : iface_clock_out
`default_nettype wire

// >>> clock_mode_power_down_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01 - code 000 gives standard interface clocking
// RULE_02 - code 001 gives alternative full-duplex timing
// RULE_03 - code 011 gives alternative 20-bit timing
// RULE_04 - code 101 gives alternative 10-bit timing
// RULE_05 - code 111 clone mode; 000 default
// RULE_06 - bit 2 drives clock on second pin
// RULE_07 - bit 2 inverts that clock in full-duplex
// RULE_08 - bit 1 inverts third pin clock
// RULE_09 - analog code 100 disables channel A only
// RULE_10 - analog code 010 disables channel B only
// RULE_11 - code 110 disables both plus support
// RULE_12 - converter bias never removed by analog codes
// RULE_13 - transmit digital bit resets low, runs
// RULE_14 - high bit stops transmit, holds outputs
// RULE_15 - bit 3 powers down receive digital
// RULE_16 - bit 2 powers down clock multiplier
// RULE_17 - bit 1 detaches multiplier output only
// RULE_18 - per-channel bits power down receive converters
// RULE_19 - unused clocking codes are reserved, ignored
module clock_mode_power_down_regs (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic SCLK,
  input wire logic SEN_N,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE_N,
  input wire logic FULL_DUPLEX_INTERFACE,
  input wire logic RX_PATH_IN_USE,
  input wire logic [cmpd_pkg::TX_WIDTH-1:0] TX_A_DATA,
  input wire logic [cmpd_pkg::TX_WIDTH-1:0] TX_B_DATA,
  output logic [cmpd_pkg::TX_WIDTH-1:0] TX_A_HELD,
  output logic [cmpd_pkg::TX_WIDTH-1:0] TX_B_HELD,
  output logic [2:0] CLOCK_MODE_CODE,
  output cmpd_pkg::timing_sel_type TIMING_SEL,
  output cmpd_pkg::power_ctrl_type POWER_CTRL,
  output logic SECOND_INTERFACE_PIN_O,
  output logic SECOND_INTERFACE_PIN_OE_N,
  output logic THIRD_INTERFACE_PIN_O,
  output logic THIRD_INTERFACE_PIN_OE_N
);
  import cmpd_pkg::*;

  typedef enum logic [1:0] {SER_IDLE, SER_ADDR, SER_DATA, SER_DONE} ser_type;

  logic sclk_s;
  logic sen_n_s;
  logic sdio_s;
  logic fd_pin_s;
  logic sclk_prev_reg;
  logic sclk_rise;
  logic sclk_fall;
  ser_type state_reg;
  logic [3:0] bit_cnt_reg;
  logic [6:0] shift_in_reg;
  logic read_reg;
  logic [6:0] addr_reg;
  logic [7:0] sdo_shift_reg;
  logic [7:0] wr_data;
  logic [7:0] instr_byte;
  logic wr_strobe;
  logic instr_done;
  logic [2:0] mode_reg;
  logic if2_en_reg;
  logic inv3_reg;
  logic [2:0] txpd_reg;
  logic txdig_reg;
  logic rxdig_reg;
  logic pll_pd_reg;
  logic pll_disc_reg;
  logic rx_a_pd_reg;
  logic rx_b_pd_reg;
  logic fd_active;

  // ==========================================================
  // pin synchronisers
  // serial clock is oversampled, so it must stay below a sixth of MCLK
  sync2 #(
    .WIDTH(4),
    .INIT(4'h4)
  ) u_sync (
    .clk(MCLK),
    .reset(RESET),
    .ce(CE),
    .d({SCLK, SEN_N, SDIO_I, FULL_DUPLEX_INTERFACE}),
    .q({sclk_s, sen_n_s, sdio_s, fd_pin_s})
  );

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      sclk_prev_reg <= 1'b0;
    end else if (CE) begin
      sclk_prev_reg <= sclk_s;
    end
  end

  assign sclk_rise = CE & sclk_s & ~sclk_prev_reg;
  assign sclk_fall = CE & ~sclk_s & sclk_prev_reg;
  assign instr_byte = {shift_in_reg, sdio_s};
  assign wr_data = {shift_in_reg, sdio_s};
  assign instr_done = (state_reg == SER_ADDR) && sclk_rise &&
    (bit_cnt_reg == LAST_BIT) && !sen_n_s;
  assign wr_strobe = (state_reg == SER_DATA) && sclk_rise &&
    (bit_cnt_reg == LAST_BIT) && !read_reg && !sen_n_s;

  // ==========================================================
  // serial frame: r/w + 7-bit address, then 8 data bits, msb first
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= SER_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_in_reg <= 7'h00;
      read_reg <= 1'b0;
      addr_reg <= 7'h00;
    end else if (CE) begin
      if (sen_n_s) begin
        state_reg <= SER_IDLE;
        bit_cnt_reg <= 4'h0;
      end else begin
        case (state_reg)
          SER_IDLE: begin
            state_reg <= SER_ADDR;
            bit_cnt_reg <= 4'h0;
          end
          SER_ADDR: begin
            if (sclk_rise) begin
              shift_in_reg <= instr_byte[6:0];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (instr_done) begin
                read_reg <= instr_byte[7];
                addr_reg <= instr_byte[6:0];
                bit_cnt_reg <= 4'h0;
                state_reg <= SER_DATA;
              end
            end
          end
          SER_DATA: begin
            if (sclk_rise) begin
              shift_in_reg <= wr_data[6:0];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == LAST_BIT) begin
                state_reg <= SER_DONE;
              end
            end
          end
          SER_DONE: begin
            // extra clocks until deselect are ignored
            state_reg <= SER_DONE;
          end
          default: begin
            state_reg <= SER_IDLE;
          end
        endcase
      end
    end
  end

  function automatic logic [7:0] read_value(input logic [6:0] addr);
    read_value = 8'h00;
    case (addr)
      ADDR_CLOCK_MODE: begin
        read_value[CM_MODE_MSB:CM_MODE_LSB] = mode_reg;
        read_value[CM_IF2_EN_BIT] = if2_en_reg;
        read_value[CM_INV3_BIT] = inv3_reg;
      end
      ADDR_POWER_DOWN: begin
        read_value[PD_TXA_MSB:PD_TXA_LSB] = txpd_reg;
        read_value[PD_TXDIG_BIT] = txdig_reg;
        read_value[PD_RXDIG_BIT] = rxdig_reg;
        read_value[PD_PLL_BIT] = pll_pd_reg;
        read_value[PD_DISC_BIT] = pll_disc_reg;
      end
      ADDR_RX_A_POWER: begin
        read_value[RX_PD_BIT] = rx_a_pd_reg;
      end
      ADDR_RX_B_POWER: begin
        read_value[RX_PD_BIT] = rx_b_pd_reg;
      end
      default: begin
        read_value = 8'h00;
      end
    endcase
  endfunction : read_value

  // ==========================================================
  // read data out, changed on falling serial clock
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      sdo_shift_reg <= 8'h00;
    end else if (CE) begin
      if (instr_done) begin
        sdo_shift_reg <= read_value(instr_byte[6:0]);
      end else if (sclk_fall && state_reg == SER_DATA &&
                   bit_cnt_reg != 4'h0) begin
        sdo_shift_reg <= {sdo_shift_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      SDIO_O <= 1'b0;
      SDIO_OE_N <= 1'b1;
    end else if (CE) begin
      SDIO_O <= sdo_shift_reg[7];
      SDIO_OE_N <= ~(state_reg == SER_DATA && read_reg && !sen_n_s);
    end
  end

  // ==========================================================
  // clocking-mode register
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      // RULE_05 default code
      mode_reg <= CLOCK_MODE_RESET[CM_MODE_MSB:CM_MODE_LSB];
      if2_en_reg <= CLOCK_MODE_RESET[CM_IF2_EN_BIT];
      inv3_reg <= CLOCK_MODE_RESET[CM_INV3_BIT];
    end else if (CE && wr_strobe && addr_reg == ADDR_CLOCK_MODE) begin
      // RULE_19 reserved codes dropped
      if (mode_valid(wr_data[CM_MODE_MSB:CM_MODE_LSB])) begin
        mode_reg <= wr_data[CM_MODE_MSB:CM_MODE_LSB];
      end
      if2_en_reg <= wr_data[CM_IF2_EN_BIT];
      inv3_reg <= wr_data[CM_INV3_BIT];
    end
  end

  // ==========================================================
  // power-down registers
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      txpd_reg <= POWER_DOWN_RESET[PD_TXA_MSB:PD_TXA_LSB];
      // RULE_13 resets low
      txdig_reg <= POWER_DOWN_RESET[PD_TXDIG_BIT];
      rxdig_reg <= POWER_DOWN_RESET[PD_RXDIG_BIT];
      pll_pd_reg <= POWER_DOWN_RESET[PD_PLL_BIT];
      pll_disc_reg <= POWER_DOWN_RESET[PD_DISC_BIT];
    end else if (CE && wr_strobe && addr_reg == ADDR_POWER_DOWN) begin
      txpd_reg <= wr_data[PD_TXA_MSB:PD_TXA_LSB];
      txdig_reg <= wr_data[PD_TXDIG_BIT];
      rxdig_reg <= wr_data[PD_RXDIG_BIT];
      pll_pd_reg <= wr_data[PD_PLL_BIT];
      pll_disc_reg <= wr_data[PD_DISC_BIT];
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      rx_a_pd_reg <= RX_POWER_RESET[RX_PD_BIT];
      rx_b_pd_reg <= RX_POWER_RESET[RX_PD_BIT];
    end else if (CE && wr_strobe) begin
      if (addr_reg == ADDR_RX_A_POWER) begin
        rx_a_pd_reg <= wr_data[RX_PD_BIT];
      end
      if (addr_reg == ADDR_RX_B_POWER) begin
        rx_b_pd_reg <= wr_data[RX_PD_BIT];
      end
    end
  end

  // ==========================================================
  // mode decode
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      CLOCK_MODE_CODE <= CLK_STD;
      TIMING_SEL <= '0;
    end else if (CE) begin
      CLOCK_MODE_CODE <= mode_reg;
      // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 one-hot decode
      TIMING_SEL <= decode_mode(mode_reg);
    end
  end

  // ==========================================================
  // power control outputs
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      POWER_CTRL <= '0;
    end else if (CE) begin
      // RULE_09 channel A, RULE_11 both
      POWER_CTRL.tx_a_out_en <= !(txpd_reg == TXPD_A ||
        txpd_reg == TXPD_BOTH);
      // RULE_10 channel B
      POWER_CTRL.tx_b_out_en <= !(txpd_reg == TXPD_B ||
        txpd_reg == TXPD_BOTH);
      // RULE_11 support circuitry
      POWER_CTRL.tx_support_pd <= (txpd_reg == TXPD_BOTH);
      // RULE_12 bias always kept for fast recovery
      POWER_CTRL.tx_bias_on <= 1'b1;
      // RULE_14 stop transmit clocks
      POWER_CTRL.tx_dig_clk_en <= ~txdig_reg;
      // RULE_15 explicit or automatic
      POWER_CTRL.rx_dig_pd <= rxdig_reg | ~RX_PATH_IN_USE;
      // RULE_16 multiplier off
      POWER_CTRL.pll_pd <= pll_pd_reg;
      // RULE_17 detach output, lock untouched
      POWER_CTRL.pll_out_connect <= ~pll_disc_reg & ~pll_pd_reg;
      // RULE_18 per-channel converters
      POWER_CTRL.rx_a_pd <= rx_a_pd_reg;
      POWER_CTRL.rx_b_pd <= rx_b_pd_reg;
    end
  end

  // ==========================================================
  // transmit sample hold
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      TX_A_HELD <= '0;
      TX_B_HELD <= '0;
    end else if (CE && !txdig_reg) begin
      // RULE_13 follow data, RULE_14 hold otherwise
      TX_A_HELD <= TX_A_DATA;
      TX_B_HELD <= TX_B_DATA;
    end
  end

  // ==========================================================
  // interface output clocks
  assign fd_active = (mode_reg == CLK_ALT_FD) ||
    (mode_reg != CLK_ALT_HALF_DUPLEX_TWENTY_BIT && mode_reg != CLK_ALT_HALF_DUPLEX_TEN_BIT && fd_pin_s);

  iface_clock_out u_clk_out (
    .clk(MCLK),
    .reset(RESET),
    .ce(CE),
    .if2_en(if2_en_reg),
    .fd_active(fd_active),
    .inv3(inv3_reg),
    .pin2_o(SECOND_INTERFACE_PIN_O),
    .pin2_oe_n(SECOND_INTERFACE_PIN_OE_N),
    .pin3_o(THIRD_INTERFACE_PIN_O),
    .pin3_oe_n(THIRD_INTERFACE_PIN_OE_N)
  );

  // ==========================================================
  // checks
  AST_STD_TIMING: assert property (@(posedge MCLK) disable iff (RESET) // RULE_01
    (CE && mode_reg == CLK_STD) |=> (TIMING_SEL == 5'b10000))
    else $error("standard timing not selected");

  AST_ALT_FD: assert property (@(posedge MCLK) disable iff (RESET) // RULE_02
    (CE && mode_reg == CLK_ALT_FD) |=> (TIMING_SEL == 5'b01000))
    else $error("alternative full-duplex timing not selected");

  AST_ALT_HALF_DUPLEX_TWENTY_BIT: assert property (@(posedge MCLK) disable iff (RESET) // RULE_03
    (CE && mode_reg == CLK_ALT_HALF_DUPLEX_TWENTY_BIT) |=> (TIMING_SEL == 5'b00100))
    else $error("alternative 20-bit timing not selected");

  AST_ALT_HALF_DUPLEX_TEN_BIT: assert property (@(posedge MCLK) disable iff (RESET) // RULE_04
    (CE && mode_reg == CLK_ALT_HALF_DUPLEX_TEN_BIT) |=> (TIMING_SEL == 5'b00010))
    else $error("alternative 10-bit timing not selected");

  AST_CLONE: assert property (@(posedge MCLK) disable iff (RESET) // RULE_05
    (CE && mode_reg == CLK_CLONE) |=> (TIMING_SEL == 5'b00001))
    else $error("clone mode not selected");

  AST_RESERVED_CODE: assert property (@(posedge MCLK) disable iff (RESET) // RULE_19
    (wr_strobe && addr_reg == ADDR_CLOCK_MODE &&
     !mode_valid(wr_data[7:5])) |=> $stable(mode_reg))
    else $error("reserved clocking code was stored");

  AST_IF2_ENABLE: assert property (@(posedge MCLK) disable iff (RESET) // RULE_06
    (CE && if2_en_reg) |=> !SECOND_INTERFACE_PIN_OE_N)
    else $error("second pin not driven when enabled");

  AST_TXA_ONLY: assert property (@(posedge MCLK) disable iff (RESET) // RULE_09
    (CE && txpd_reg == TXPD_A) |=>
      (!POWER_CTRL.tx_a_out_en && POWER_CTRL.tx_b_out_en &&
       !POWER_CTRL.tx_support_pd))
    else $error("channel A power-down wrong");

  AST_TXB_ONLY: assert property (@(posedge MCLK) disable iff (RESET) // RULE_10
    (CE && txpd_reg == TXPD_B) |=>
      (POWER_CTRL.tx_a_out_en && !POWER_CTRL.tx_b_out_en &&
       !POWER_CTRL.tx_support_pd))
    else $error("channel B power-down wrong");

  AST_TX_BOTH: assert property (@(posedge MCLK) disable iff (RESET) // RULE_11
    (CE && txpd_reg == TXPD_BOTH) |=>
      (POWER_CTRL.tx_support_pd && !POWER_CTRL.tx_a_out_en &&
       !POWER_CTRL.tx_b_out_en))
    else $error("full transmit power-down wrong");

  AST_BIAS_KEPT: assert property (@(posedge MCLK) disable iff (RESET) // RULE_12
    (CE && txpd_reg != 3'h0) |=> POWER_CTRL.tx_bias_on)
    else $error("converter bias removed");

  AST_TX_FOLLOW: assert property (@(posedge MCLK) disable iff (RESET) // RULE_13
    (CE && !txdig_reg) |=> (TX_A_HELD == $past(TX_A_DATA) &&
      POWER_CTRL.tx_dig_clk_en))
    else $error("transmit path not running");

  AST_TX_HOLD: assert property (@(posedge MCLK) disable iff (RESET) // RULE_14
    (txdig_reg ##1 txdig_reg) |-> ($stable(TX_A_HELD) &&
      $stable(TX_B_HELD)))
    else $error("transmit outputs moved while powered down");

  AST_RX_DIG: assert property (@(posedge MCLK) disable iff (RESET) // RULE_15
    (CE && rxdig_reg) |=> POWER_CTRL.rx_dig_pd)
    else $error("receive digital not powered down");

  AST_PLL_PD: assert property (@(posedge MCLK) disable iff (RESET) // RULE_16
    (CE && pll_pd_reg) |=> (POWER_CTRL.pll_pd &&
      !POWER_CTRL.pll_out_connect))
    else $error("multiplier not powered down");

  AST_PLL_DISC: assert property (@(posedge MCLK) disable iff (RESET) // RULE_17
    (CE && pll_disc_reg && !pll_pd_reg) |=>
      (!POWER_CTRL.pll_out_connect && !POWER_CTRL.pll_pd))
    else $error("disconnect changed multiplier power");

  AST_RX_ANALOG: assert property (@(posedge MCLK) disable iff (RESET) // RULE_18
    CE |=> (POWER_CTRL.rx_a_pd == $past(rx_a_pd_reg) &&
      POWER_CTRL.rx_b_pd == $past(rx_b_pd_reg)))
    else $error("receive converter power-down mismatch");
endmodule : clock_mode_power_down_regs
`default_nettype wire

// >>> cmpd_back_end.sv
`timescale 1ns/1ps
`default_nettype none
module cmpd_back_end (
  input wire logic mclk,
  input wire logic pin3,
  output logic [9:0] tx_a,
  output logic [9:0] tx_b,
  output logic [9:0] prev_a,
  output var int edges
);
  // ==========================================================
  // sample source
  initial begin
    tx_a = 10'h000;
    tx_b = 10'h000;
    prev_a = 10'h000;
    edges = 0;
  end
  // fresh word every cycle, so a stale hold cannot pass
  always @(posedge mclk) begin
    prev_a <= tx_a;
    #1;
    tx_a = 10'($urandom);
    tx_b = 10'($urandom);
  end
  // ==========================================================
  // clock consumer
  always @(posedge pin3) begin
    edges <= edges + 1;
  end
endmodule : cmpd_back_end
`default_nettype wire

// >>> clock_mode_power_down_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_mode_power_down_regs_tb;
  import cmpd_pkg::*;
  logic mclk, reset, sclk, sen_n, sdo, sdo_en, fd, rx_use;
  logic sdio_o, sdio_oe_n, p2, p2_oe_n, p3, p3_oe_n;
  logic [9:0] tx_a, tx_b, prev_a, held_a, held_b, ha, hb;
  logic [2:0] code_o;
  timing_sel_type sel;
  power_ctrl_type pwr;
  logic [7:0] m [1:4];
  logic [7:0] q;
  int fail_count, n_checks, cycles, edges, edge_mark;
  // released line is pulled up
  wire logic sdio_w = !sdio_oe_n ? sdio_o : (sdo_en ? sdo : 1'b1);

  clock_mode_power_down_regs clock_mode_power_down_regs_i (
    .MCLK(mclk), .RESET(reset), .CE(1'b1), .SCLK(sclk), .SEN_N(sen_n),
    .SDIO_I(sdio_w), .SDIO_O(sdio_o), .SDIO_OE_N(sdio_oe_n),
    .FULL_DUPLEX_INTERFACE(fd), .RX_PATH_IN_USE(rx_use),
    .TX_A_DATA(tx_a), .TX_B_DATA(tx_b), .TX_A_HELD(held_a),
    .TX_B_HELD(held_b), .CLOCK_MODE_CODE(code_o), .TIMING_SEL(sel),
    .POWER_CTRL(pwr), .SECOND_INTERFACE_PIN_O(p2),
    .SECOND_INTERFACE_PIN_OE_N(p2_oe_n), .THIRD_INTERFACE_PIN_O(p3),
    .THIRD_INTERFACE_PIN_OE_N(p3_oe_n)
  );
  cmpd_back_end back_end (
    .mclk(mclk), .pin3(p3), .tx_a(tx_a), .tx_b(tx_b), .prev_a(prev_a),
    .edges(edges)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ==========================================================
  // checking and serial master
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic chk_out(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: output %h, want %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: read %h, want %h", $time, got, exp);
    end
  endtask : chk_reg

  // phases of 6 cycles leave margin over the synchroniser lag
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [7:0] d);
    logic [15:0] w;
    w = {rd, a, d};
    sen_n = 1'b0;
    tick(4);
    for (int i = 15; i >= 0; i--) begin
      sdo = w[i];
      sdo_en = (i > 7) || !rd;
      tick(6);
      if (i < 8) q[i] = sdio_w;
      sclk = 1'b1;
      tick(6);
      sclk = 1'b0;
    end
    tick(6);
    sen_n = 1'b1;
    sdo_en = 1'b0;
    tick(8);
  endtask : xfer

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [2:0] c;
    c = d[7:5];
    xfer(1'b0, a, d);
    case (a)
      7'h01: m[1] = {(c == 3'h0 || c[0]) ? c : m[1][7:5], d[4:0] & 5'h06};
      7'h02: m[2] = d & 8'hfe;
      7'h03, 7'h04: m[int'(a)] = d & 8'h80;
      default: ;
    endcase
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    xfer(1'b1, a, 8'h00);
    chk_reg(q, exp);
  endtask : rd_chk

  task automatic check_outs();
    logic [2:0] c, t;
    logic [9:0] ep;
    logic fda, t3;
    c = m[1][7:5];
    t = m[2][7:5];
    fda = c == 3'h1 || (c != 3'h3 && c != 3'h5 && fd);
    ep = {!(t == 3'h4 || t == 3'h6), !(t == 3'h2 || t == 3'h6), t == 3'h6,
          1'b1, !m[2][4], m[2][3] | !rx_use, m[2][2], !(m[2][2] | m[2][1]),
          m[3][7], m[4][7]};
    @(negedge mclk);
    chk_out({7'h00, code_o}, {7'h00, c});
    chk_out({5'h00, sel}, {5'h00, c == 3'h0, c == 3'h1, c == 3'h3,
            c == 3'h5, c == 3'h7});
    chk_out(pwr, ep);
    chk_out({9'h000, p2_oe_n}, {9'h000, !m[1][2]});
    chk_out({9'h000, p3_oe_n}, 10'h000);
    t3 = p3;
    if (m[1][2]) chk_out({9'h000, p2 ^ p3}, {9'h000, fda ^ m[1][1]});
    else chk_out({9'h000, p2}, 10'h000);
    @(negedge mclk);
    chk_out({9'h000, p3}, {9'h000, !t3});
  endtask : check_outs

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    reset = 1'b1;
    {sclk, sdo, sdo_en, fd} = 4'h0;
    sen_n = 1'b1;
    rx_use = 1'b1;
    {fail_count, n_checks, cycles} = {32'd0, 32'd0, 32'd0};
    void'($urandom(17410));
    tick(3);
    reset = 1'b0;
    tick(2);
    for (int a = 1; a <= 4; a++) begin
      m[a] = 8'h00;
      rd_chk(7'(a), 8'h00);
    end
    check_outs();
    // half-rate clock: five rises in ten cycles
    edge_mark = edges;
    tick(10);
    chk_out(10'(edges - edge_mark), 10'h005);
    for (int i = 0; i < 16; i++) begin
      fd = 1'($urandom);
      wr(7'h01, {i[2:0], 2'($urandom), i[3], 2'($urandom)});
      rd_chk(7'h01, m[1]);
      check_outs();
    end
    for (int i = 0; i < 8; i++) begin
      rx_use = 1'($urandom);
      wr(7'h02, {i[2:0], 1'b0, 4'($urandom)});
      rd_chk(7'h02, m[2]);
      check_outs();
      chk_out(held_a, prev_a);
    end
    wr(7'h02, 8'h10);
    check_outs();
    ha = held_a;
    hb = held_b;
    tick(5);
    chk_out(held_a, ha);
    chk_out(held_b, hb);
    wr(7'h02, 8'h00);
    check_outs();
    chk_out(held_a, prev_a);
    wr(7'h03, 8'hff);
    wr(7'h04, 8'h7f);
    rd_chk(7'h03, 8'h80);
    rd_chk(7'h04, 8'h00);
    check_outs();
    wr(7'h04, 8'h80);
    check_outs();
    wr(7'h05, 8'hff);
    rd_chk(7'h05, 8'h00);
    rd_chk(7'h01, m[1]);
    summarize();
  end
endmodule : clock_mode_power_down_regs_tb
`default_nettype wire
